// File: core/ucb_uart.sv
// Serial transceiver control, shared data register and baud generator
// ----------------------------------------------------------------
// Operation
// - Clearing transmit enable aborts transmission, flushes buffers, floats TX.
// - TX driven only with transmit enable, mode select and master enable set.
// - Clearing receive enable aborts reception, flushes receive buffers, floats RX.
// - Receiver owns RX only with receive, mode and master enables set.
// - Baud is clock over 64*(N+1), or over 16*(N+1) in fast mode.
// - A free-running 8-bit counter, period set by divisor 0 to 255.
// - Address detect: word with top bit set is an address, raises irq.
// - Address detect: word with top bit clear is dropped, no irq.
// - Wake enabled and clock off: RX falling edge raises wake request.
// - No wake-up while clock runs or wake enable is clear.
// - Receive irq enable lets overrun or receive-full set module flag.
// - Transmit-idle irq enable lets idle flag rising set module flag.
// - Transmit-empty irq enable lets empty flag rising set module flag.
// - One data location: writes load transmit, reads return received.
// - Master disable flushes, resets baud counter, clears transmit and receive enables and resets status flags.
// - Characters travel least significant bit first, NRZ.
// ----------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none

module ucb_uart (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ucb_pkg::AW-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic irq_o,
    input wire logic rx_i,
    output logic rx_own_o,
    output logic tx_o,
    output logic tx_oe_o
);
    import ucb_pkg::*;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    function automatic logic hit(input logic [AW-1:0] a,
                                 input logic [AW-1:0] r);
        hit = (a == r);
    endfunction : hit

    logic ack_reg;
    logic [31:0] dat_reg;
    logic req;
    logic wr;
    logic rd;
    assign req = cyc_i & stb_i & ~ack_reg;
    assign wr = req & we_i & sel_i[0];
    assign rd = req & ~we_i;
    assign ack_o = ack_reg;
    assign dat_o = dat_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end

    logic [7:0] ctrl2_reg;
    logic [7:0] baud_reg;
    logic [7:0] conf_reg;
    logic [1:0] irq_st_reg;
    logic [1:0] irq_en_reg;
    logic men;
    logic tx_on;
    logic rx_on;
    logic clk_run;
    assign men = conf_reg[C_MEN];
    assign clk_run = ~conf_reg[C_CLKOFF];
    assign tx_on = men & conf_reg[C_MODE] & ctrl2_reg[B_TXEN];
    assign rx_on = men & conf_reg[C_MODE] & ctrl2_reg[B_RXEN];
    assign tx_oe_o = tx_on;
    assign rx_own_o = rx_on;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl2_reg <= RST_CTRL2;
        end else begin
            if (wr && hit(adr_i, ADR_CTRL2)) begin
                ctrl2_reg <= dat_i[7:0];
            end
            if (!men) begin
                ctrl2_reg[B_TXEN] <= 1'b0;
                ctrl2_reg[B_RXEN] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            baud_reg <= RST_BAUD;
            conf_reg <= RST_CONF;
            irq_en_reg <= RST_IRQ;
        end else if (wr) begin
            if (hit(adr_i, ADR_BAUD)) begin
                baud_reg <= dat_i[7:0];
            end
            if (hit(adr_i, ADR_CONF)) begin
                conf_reg <= dat_i[7:0] & CONF_WMASK;
            end
            if (hit(adr_i, ADR_IRQ_EN)) begin
                irq_en_reg <= dat_i[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Baud generator
    // ------------------------------------------------------------
    // Prescaler of four gives the slow mode its extra factor, so one
    // 8-bit counter serves both speeds.
    logic [1:0] presc_reg;
    logic [7:0] brg_reg;
    logic pre_tick;
    logic stick;
    assign pre_tick = ctrl2_reg[B_BRGH] | (presc_reg == LOW_PRESC);
    assign stick = men & clk_run & pre_tick & (brg_reg == 8'h00);

    always_ff @(posedge clk_i) begin
        if (rst_i || !men) begin
            presc_reg <= 2'h0;
            brg_reg <= 8'h00;
        end else if (clk_run) begin
            presc_reg <= presc_reg + 2'h1;
            if (pre_tick) begin
                if (brg_reg == 8'h00) begin
                    brg_reg <= baud_reg;
                end else begin
                    brg_reg <= brg_reg - 8'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    ucb_tx_t tx_st;
    logic [8:0] tx_sh;
    logic [3:0] tx_ph;
    logic [3:0] tx_bit;
    logic [7:0] tx_hold;
    logic tx_h8;
    logic tx_empty;
    logic tx_line;
    logic tx_load;
    logic tx_idle;
    logic tx_end;
    logic [3:0] last_bit;
    assign last_bit = conf_reg[C_NINE] ? BITS9_LAST : BITS8_LAST;
    assign tx_load = tx_on & (tx_st == TX_IDLE) & ~tx_empty;
    assign tx_idle = tx_empty & (tx_st == TX_IDLE);
    assign tx_end = stick & (tx_ph == OVS_LAST);
    assign tx_o = tx_line;

    // Writes while the holding slot is full are dropped
    always_ff @(posedge clk_i) begin
        if (rst_i || !tx_on) begin
            tx_empty <= 1'b1;
            tx_hold <= 8'h00;
            tx_h8 <= 1'b0;
        end else if (tx_load) begin
            tx_empty <= 1'b1;
        end else if (wr && hit(adr_i, ADR_DATA) && tx_empty) begin
            tx_hold <= dat_i[7:0];
            tx_h8 <= conf_reg[C_TX8];
            tx_empty <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !tx_on) begin
            tx_st <= TX_IDLE;
            tx_sh <= 9'h000;
            tx_ph <= 4'h0;
            tx_bit <= 4'h0;
            tx_line <= 1'b1;
        end else begin
            if (stick) begin
                tx_ph <= tx_ph + 4'h1;
            end
            case (tx_st)
                TX_IDLE: begin
                    if (tx_load) begin
                        tx_sh <= {tx_h8, tx_hold};
                        tx_st <= TX_START;
                        tx_ph <= 4'h0;
                        tx_bit <= 4'h0;
                        tx_line <= 1'b0;
                    end
                end
                TX_START: begin
                    if (tx_end) begin
                        tx_st <= TX_DATA;
                        tx_line <= tx_sh[0];
                    end
                end
                TX_DATA: begin
                    if (tx_end) begin
                        tx_sh <= tx_sh >> 1;
                        tx_bit <= tx_bit + 4'h1;
                        if (tx_bit == last_bit) begin
                            tx_st <= TX_STOP;
                            tx_line <= 1'b1;
                        end else begin
                            tx_line <= tx_sh[1];
                        end
                    end
                end
                TX_STOP: begin
                    if (tx_end) begin
                        tx_st <= TX_IDLE;
                    end
                end
                default: begin
                    tx_st <= TX_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    logic rx_s1;
    logic rx_s2;
    logic rx_d;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_d <= 1'b1;
        end else begin
            rx_s1 <= rx_i;
            rx_s2 <= rx_s1;
            rx_d <= rx_s2;
        end
    end

    ucb_rx_t rx_st;
    logic [8:0] rx_sh;
    logic [3:0] rx_ph;
    logic [3:0] rx_bit;
    logic rx_done;
    logic [8:0] rx_word;
    logic addr_bit;
    logic rx_keep;
    assign rx_word = conf_reg[C_NINE] ? rx_sh : {1'b0, rx_sh[8:1]};
    assign addr_bit = conf_reg[C_NINE] ? rx_word[8] : rx_word[7];
    assign rx_keep = ~ctrl2_reg[B_ADDEN] | addr_bit;

    always_ff @(posedge clk_i) begin
        if (rst_i || !rx_on) begin
            rx_st <= RX_IDLE;
            rx_sh <= 9'h000;
            rx_ph <= 4'h0;
            rx_bit <= 4'h0;
            rx_done <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (stick) begin
                rx_ph <= rx_ph + 4'h1;
            end
            case (rx_st)
                RX_IDLE: begin
                    if (stick && !rx_s2) begin
                        rx_st <= RX_START;
                        rx_ph <= 4'h0;
                    end
                end
                RX_START: begin
                    // Mid-bit check rejects glitches as false starts
                    if (stick && rx_ph == OVS_MID) begin
                        rx_st <= rx_s2 ? RX_IDLE : RX_DATA;
                        rx_ph <= 4'h0;
                        rx_bit <= 4'h0;
                    end
                end
                RX_DATA: begin
                    if (stick && rx_ph == OVS_LAST) begin
                        rx_sh <= {rx_s2, rx_sh[8:1]};
                        rx_bit <= rx_bit + 4'h1;
                        if (rx_bit == last_bit) begin
                            rx_st <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (stick && rx_ph == OVS_LAST) begin
                        rx_st <= RX_IDLE;
                        rx_done <= 1'b1;
                    end
                end
                default: begin
                    rx_st <= RX_IDLE;
                end
            endcase
        end
    end

    logic [7:0] rx_data_reg;
    logic rx8_reg;
    logic rx_full;
    logic ovr;
    logic rd_data;
    assign rd_data = rd & hit(adr_i, ADR_DATA);

    // A word landing in the cycle of a read is kept, not lost
    always_ff @(posedge clk_i) begin
        if (rst_i || !rx_on) begin
            rx_full <= 1'b0;
            ovr <= 1'b0;
            rx_data_reg <= 8'h00;
            rx8_reg <= 1'b0;
        end else begin
            if (rd_data) begin
                rx_full <= 1'b0;
                ovr <= 1'b0;
            end
            if (rx_done && rx_keep) begin
                if (rx_full && !rd_data) begin
                    ovr <= 1'b1;
                end else begin
                    rx_data_reg <= rx_word[7:0];
                    rx8_reg <= rx_word[8];
                    rx_full <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    logic tx_idle_d;
    logic tx_empty_d;
    logic [1:0] irq_set;
    logic [1:0] irq_clr;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_idle_d <= 1'b1;
            tx_empty_d <= 1'b1;
        end else begin
            tx_idle_d <= tx_idle;
            tx_empty_d <= tx_empty;
        end
    end

    assign irq_set[I_MOD] = (ctrl2_reg[B_RIE] & (rx_full | ovr))
        | (ctrl2_reg[B_TIIE] & tx_idle & ~tx_idle_d)
        | (ctrl2_reg[B_TEIE] & tx_empty & ~tx_empty_d);
    // Only sensed while the block clock is stopped
    assign irq_set[I_WAKE] = ctrl2_reg[B_WAKE] & ~clk_run
        & rx_d & ~rx_s2;
    assign irq_clr = (wr && hit(adr_i, ADR_IRQ_CLR)) ? dat_i[1:0] : 2'h0;
    assign irq_o = |(irq_st_reg & irq_en_reg);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_st_reg <= RST_IRQ;
        end else begin
            irq_st_reg <= (irq_st_reg & ~irq_clr) | irq_set;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= 32'h0000_0000;
        end else if (rd) begin
            dat_reg <= 32'h0000_0000;
            case (adr_i)
                ADR_CTRL2: dat_reg[7:0] <= ctrl2_reg;
                ADR_DATA: dat_reg[7:0] <= rx_data_reg;
                ADR_BAUD: dat_reg[7:0] <= baud_reg;
                ADR_CONF: begin
                    dat_reg[7:0] <= {conf_reg[7:2], rx8_reg, 1'b0};
                end
                ADR_STAT: begin
                    dat_reg[S_OVR] <= ovr;
                    dat_reg[S_RXIDLE] <= (rx_st == RX_IDLE);
                    dat_reg[S_RXFULL] <= rx_full;
                    dat_reg[S_TXIDLE] <= tx_idle;
                    dat_reg[S_TXEMP] <= tx_empty;
                end
                ADR_IRQ_ST: dat_reg[1:0] <= irq_st_reg;
                ADR_IRQ_EN: dat_reg[1:0] <= irq_en_reg;
                default: dat_reg <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_tx_abort:
    assert property ($fell(ctrl2_reg[B_TXEN])
        |=> tx_st == TX_IDLE && tx_empty && tx_line)
        else $error("transmitter not reset after disable");
    a_tx_owned:
    assert property (tx_st != TX_IDLE |-> $past(tx_oe_o))
        else $error("transmitter active without pin drive");
    a_rx_abort:
    assert property (!rx_on |=> rx_st == RX_IDLE && !rx_full && !ovr)
        else $error("receiver not reset while disabled");
    a_baud_fast:
    assert property (stick && ctrl2_reg[B_BRGH] && baud_reg == 8'h00
        ##1 men && clk_run && ctrl2_reg[B_BRGH] && baud_reg == 8'h00
        |-> stick)
        else $error("fast mode divisor zero missed a tick");
    a_baud_slow:
    assert property (stick && !ctrl2_reg[B_BRGH]
        |=> (!stick || ctrl2_reg[B_BRGH])[*3])
        else $error("slow mode tick spacing below four");
    a_brg_reload:
    assert property (stick ##1 men |-> brg_reg == $past(baud_reg))
        else $error("baud counter did not reload");
    a_addr_take:
    assert property (rx_done && rx_on && ctrl2_reg[B_ADDEN] && addr_bit
        && !rx_full |=> rx_full)
        else $error("address word not accepted");
    a_addr_drop:
    assert property (rx_done && ctrl2_reg[B_ADDEN] && !addr_bit
        && !rx_full |=> !rx_full)
        else $error("data word kept under address detect");
    a_wake_req:
    assert property (ctrl2_reg[B_WAKE] && !clk_run && $fell(rx_s2)
        |=> irq_st_reg[I_WAKE])
        else $error("wake request not raised");
    a_rx_irq:
    assert property (ctrl2_reg[B_RIE] && rx_full |=> irq_st_reg[I_MOD])
        else $error("receive event did not set module flag");
    a_master_off:
    assert property (!men |=> !ctrl2_reg[B_TXEN] && tx_empty
        && brg_reg == 8'h00)
        else $error("master disable left state behind");
    a_ack_pulse:
    assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

endmodule : ucb_uart

`default_nettype wire

// File: core/ucb_pkg.sv
// Constants and types shared by the serial control and baud block
`default_nettype none

package ucb_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int AW = 5;
    localparam logic [AW-1:0] ADR_CTRL2 = 5'h00;
    localparam logic [AW-1:0] ADR_DATA = 5'h04;
    localparam logic [AW-1:0] ADR_BAUD = 5'h08;
    localparam logic [AW-1:0] ADR_CONF = 5'h0C;
    localparam logic [AW-1:0] ADR_STAT = 5'h10;
    localparam logic [AW-1:0] ADR_IRQ_ST = 5'h14;
    localparam logic [AW-1:0] ADR_IRQ_CLR = 5'h18;
    localparam logic [AW-1:0] ADR_IRQ_EN = 5'h1C;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int B_TXEN = 7;
    localparam int B_RXEN = 6;
    localparam int B_BRGH = 5;
    localparam int B_ADDEN = 4;
    localparam int B_WAKE = 3;
    localparam int B_RIE = 2;
    localparam int B_TIIE = 1;
    localparam int B_TEIE = 0;
    localparam int C_MEN = 7;
    localparam int C_NINE = 6;
    localparam int C_MODE = 5;
    localparam int C_CLKOFF = 4;
    localparam int C_RX8 = 1;
    localparam int C_TX8 = 0;
    localparam int S_OVR = 4;
    localparam int S_RXIDLE = 3;
    localparam int S_RXFULL = 2;
    localparam int S_TXIDLE = 1;
    localparam int S_TXEMP = 0;
    localparam int I_MOD = 0;
    localparam int I_WAKE = 1;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CTRL2 = 8'h00;
    localparam logic [7:0] RST_BAUD = 8'h00;
    localparam logic [7:0] RST_CONF = 8'h00;
    localparam logic [7:0] CONF_WMASK = 8'hF1;
    localparam logic [1:0] RST_IRQ = 2'h0;
    localparam logic [1:0] LOW_PRESC = 2'h3;
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [3:0] OVS_MID = 4'h7;
    localparam logic [3:0] BITS8_LAST = 4'h7;
    localparam logic [3:0] BITS9_LAST = 4'h8;

    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_START = 4'h2,
        TX_DATA = 4'h4,
        TX_STOP = 4'h8
    } ucb_tx_t;

    typedef enum logic [3:0] {
        RX_IDLE = 4'h1,
        RX_START = 4'h2,
        RX_DATA = 4'h4,
        RX_STOP = 4'h8
    } ucb_rx_t;

endpackage : ucb_pkg

`default_nettype wire

// File: verif/ucb_remote_model.sv
// Remote serial transceiver on the far side of the TX and RX lines
`timescale 1ns/10ps
`default_nettype none

module ucb_remote_model (
    input wire logic clk_i,
    input wire logic [15:0] bit_clks_i,
    input wire logic line_i,
    output logic line_o,
    output logic [7:0] got_o,
    output logic got_stb_o
);
    initial begin
        line_o = 1'b1;
        got_o = 8'h00;
        got_stb_o = 1'b0;
    end

    // ----------------------------------------
    // Sender: start, 8 or 9 bits LSB first, stop
    // ----------------------------------------
    task automatic send(input logic [8:0] b, input int nb = 8);
        for (int i = 0; i < nb + 2; i++) begin
            line_o <= (i == 0) ? 1'b0 : (i == nb + 1) ? 1'b1
                : b[i-1];
            repeat (bit_clks_i) @(posedge clk_i);
        end
    endtask : send

    // ----------------------------------------
    // Receiver: samples each bit at its middle
    // ----------------------------------------
    always begin : rcv
        logic [7:0] sh;
        @(posedge clk_i);
        if (line_i === 1'b0) begin
            repeat (bit_clks_i / 2) @(posedge clk_i);
            for (int i = 0; i < 8; i++) begin
                repeat (bit_clks_i) @(posedge clk_i);
                sh[i] = line_i;
            end
            repeat (bit_clks_i) @(posedge clk_i);
            // A missing stop bit is handed on inverted so it cannot match
            got_o <= (line_i === 1'b1) ? sh : ~sh;
            got_stb_o <= 1'b1;
            @(posedge clk_i);
            got_stb_o <= 1'b0;
        end
    end
endmodule : ucb_remote_model

`default_nettype wire

// File: verif/ucb_uart_tb_top.sv
// Self-checking bench for the serial control and baud block
`timescale 1ns/10ps
`default_nettype none

module ucb_uart_tb_top;
    import ucb_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [AW-1:0] adr = '0;
    logic [3:0] sel = 4'h0, wsel = 4'hF;
    logic [31:0] dat = 32'h0, dat_o;
    logic ack_o, irq_o, rx_line, rx_own_o, tx_o, tx_oe_o, tx_pin, got_stb;
    logic [7:0] got, b;
    logic [15:0] bclk = 16'h0010, e;
    logic [31:0] rs = 32'h0000AAF9;
    logic ign = 1'b0;
    logic [15:0] rdq[$];
    logic [7:0] txq[$];
    int errors = 0, checks = 0;

    // Floated TX line is held high by a pull-up
    assign tx_pin = tx_oe_o ? tx_o : 1'b1;
    always #20 clk_i = ~clk_i;

    ucb_uart i_ucb_uart (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
        .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .rx_i(rx_line),
        .rx_own_o(rx_own_o), .tx_o(tx_o), .tx_oe_o(tx_oe_o));
    ucb_remote_model i_ucb_remote_model (.clk_i(clk_i), .bit_clks_i(bclk),
        .line_i(tx_pin), .line_o(rx_line), .got_o(got),
        .got_stb_o(got_stb));

    // ----------------------------------------
    // Checking and reporting
    // ----------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, g, x);
        end
    endtask : chk

    task automatic final_report();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    // Read data and serial bytes are compared as they appear
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we === 1'b0 && rdq.size() > 0) begin
            e = rdq.pop_front();
            chk(dat_o & {24'hFFFFFF, e[15:8]}, {24'h0, e[7:0]});
        end
        if (got_stb === 1'b1 && !ign) begin
            if (txq.size() == 0) chk(32'h1, 32'h0);
            else chk({24'h0, got}, {24'h0, txq.pop_front()});
        end
    end

    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    task automatic wb(input logic [AW-1:0] a, input logic w,
                      input logic [7:0] d);
        int n;
        adr <= a;
        we <= w;
        dat <= {24'h0, d};
        sel <= wsel;
        cyc <= 1'b1;
        stb <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            final_report();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
        wb(a, 1'b1, d);
    endtask : wr

    task automatic rd(input logic [AW-1:0] a, input logic [7:0] m,
                      input logic [7:0] x);
        rdq.push_back({m, x});
        wb(a, 1'b0, 8'h00);
    endtask : rd

    task automatic wait_tx();
        int n;
        n = 0;
        while (txq.size() > 0 && n < 20000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 20000) begin
            errors++;
            final_report();
        end
    endtask : wait_tx

    task automatic tx(input logic [7:0] d);
        txq.push_back(d);
        wr(ADR_DATA, d);
        wait_tx();
    endtask : tx

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ADR_CTRL2, 8'hFF, RST_CTRL2);
        rd(ADR_BAUD, 8'hFF, RST_BAUD);
        chk({tx_oe_o, rx_own_o, irq_o}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            rs = xs(rs);
            wr(ADR_BAUD, rs[7:0]);
            rd(ADR_BAUD, 8'hFF, rs[7:0]);
        end
        // A write without the low byte lane selected is ignored
        wsel = {rs[11:9], 1'b0};
        wr(ADR_BAUD, ~rs[7:0]);
        wsel = 4'hF;
        rd(ADR_BAUD, 8'hFF, rs[7:0]);
        // Counter starts from zero so the first tick is not delayed
        wr(ADR_BAUD, 8'h00);
        wr(ADR_CONF, 8'hA0);
        wr(ADR_IRQ_EN, 8'h01);
        // Fast N=0, fast N=2, slow N=0
        for (int k = 0; k < 3; k++) begin
            wr(ADR_BAUD, (k == 1) ? 8'h02 : 8'h00);
            wr(ADR_CTRL2, (k == 2) ? 8'hC0 : 8'hE0);
            bclk = (k == 2) ? 16'd64 : (k == 1) ? 16'd48 : 16'd16;
            chk({tx_oe_o, rx_own_o}, 32'h3);
            rs = xs(rs);
            tx(rs[7:0]);
            rs = xs(rs);
            b = rs[7:0];
            i_ucb_remote_model.send(b);
            rd(ADR_DATA, 8'hFF, b);
            chk(irq_o, 32'h0);
        end
        bclk = 16'd16;
        wr(ADR_CTRL2, 8'h64);
        wr(ADR_IRQ_CLR, 8'h03);
        i_ucb_remote_model.send(8'h5A);
        chk(irq_o, 32'h1);
        rd(ADR_IRQ_ST, 8'h01, 8'h01);
        rd(ADR_DATA, 8'hFF, 8'h5A);
        wr(ADR_IRQ_CLR, 8'h03);
        chk(irq_o, 32'h0);
        wr(ADR_CTRL2, 8'hA2);
        wr(ADR_IRQ_CLR, 8'h03);
        tx(8'h96);
        // Idle flag rises only once the stop bit is out
        repeat (24) @(posedge clk_i);
        chk(irq_o, 32'h1);
        wr(ADR_CTRL2, 8'hA1);
        wr(ADR_IRQ_CLR, 8'h03);
        tx(8'h3C);
        chk(irq_o, 32'h1);
        // Address detect: data word dropped, address word kept
        wr(ADR_CTRL2, 8'h74);
        rd(ADR_DATA, 8'h00, 8'h00);
        wr(ADR_IRQ_CLR, 8'h03);
        i_ucb_remote_model.send(8'h35);
        rd(ADR_STAT, 8'h04, 8'h00);
        chk(irq_o, 32'h0);
        i_ucb_remote_model.send(8'hA5);
        chk(irq_o, 32'h1);
        rd(ADR_DATA, 8'hFF, 8'hA5);
        // Nine-bit frames: the ninth bit is the address bit
        wr(ADR_CONF, 8'hE0);
        i_ucb_remote_model.send(9'h135, 9);
        rd(ADR_CONF, 8'h02, 8'h02);
        rd(ADR_DATA, 8'hFF, 8'h35);
        wr(ADR_CONF, 8'hA0);
        // Abort a frame in each direction
        wr(ADR_CTRL2, 8'hA0);
        wr(ADR_DATA, 8'hF0);
        repeat (40) @(posedge clk_i);
        ign = 1'b1;
        wr(ADR_CTRL2, 8'h20);
        chk(tx_oe_o, 32'h0);
        rd(ADR_STAT, 8'h02, 8'h02);
        repeat (200) @(posedge clk_i);
        ign = 1'b0;
        wr(ADR_CTRL2, 8'h60);
        fork
            i_ucb_remote_model.send(8'h81);
            begin
                repeat (60) @(posedge clk_i);
                wr(ADR_CTRL2, 8'h20);
                chk(rx_own_o, 32'h0);
            end
        join
        rd(ADR_STAT, 8'h0C, 8'h08);
        // Wake-up only while the clock is stopped
        wr(ADR_CTRL2, 8'h08);
        wr(ADR_IRQ_EN, 8'h02);
        wr(ADR_IRQ_CLR, 8'h03);
        i_ucb_remote_model.send(8'h00);
        rd(ADR_IRQ_ST, 8'h02, 8'h00);
        wr(ADR_CONF, 8'hB0);
        i_ucb_remote_model.send(8'h00);
        rd(ADR_IRQ_ST, 8'h02, 8'h02);
        chk(irq_o, 32'h1);
        // Master disable resets status flags and transmit and receive enables
        wr(ADR_CTRL2, 8'hE0);
        wr(ADR_CONF, 8'h00);
        rd(ADR_STAT, 8'hFF, 8'h0B);
        rd(ADR_CTRL2, 8'hE0, 8'h20);
        chk({tx_oe_o, rx_own_o}, 32'h0);
        repeat (4) @(posedge clk_i);
        chk(rdq.size() + txq.size(), 32'h0);
        final_report();
    end
endmodule : ucb_uart_tb_top

`default_nettype wire
